// ---- rtl/scd_pkg.sv ----
/*
  Constants for the serial command decoder of the measurement converter.
  Assumes nothing beyond a SystemVerilog-2012 tool.
*/
package scd_pkg;
  // Register file
  localparam int             NREG        = 18;
  localparam logic [7:0]     REG_DFLT    = 8'h00;
  localparam logic [4:0]     MODE_REG    = 5'h04;
  localparam int             SINGLE_BIT  = 5;
  localparam int             EXTCLK_BIT  = 6;
  localparam logic [4:0]     SYS_REG     = 5'h09;
  localparam int             TMO_BIT     = 1;
  localparam logic [4:0]     OFC_BASE    = 5'h0a;
  localparam logic [4:0]     FSC_BASE    = 5'h0d;
  localparam logic [31:0]    RESTART_SET = 32'h0000_02fc;
  // Command codes; the C7 ones are the upper seven bits where the last bit is ignored
  localparam logic [6:0]     C7_WAKE     = 7'h01;
  localparam logic [6:0]     C7_SLEEP    = 7'h02;
  localparam logic [6:0]     C7_RESET    = 7'h03;
  localparam logic [6:0]     C7_START    = 7'h04;
  localparam logic [6:0]     C7_STOP     = 7'h05;
  localparam logic [6:0]     C7_RDATA    = 7'h09;
  localparam logic [7:0]     C_NOP       = 8'h00;
  localparam logic [7:0]     C_SYS_OFF   = 8'h16;
  localparam logic [7:0]     C_SYS_GAIN  = 8'h17;
  localparam logic [7:0]     C_SELF_OFF  = 8'h19;
  localparam logic [2:0]     C3_REGISTER_READ_CMD     = 3'b001;
  localparam logic [2:0]     C3_REGISTER_WRITE_CMD     = 3'b010;
  // Timing in converter clock periods
  localparam logic [1:0]     SLEEP_TCLK  = 2'h2;
  localparam int             TMO_TCLK    = 32768;
  localparam int             TMO_W       = 16;
  // Data path
  localparam int             DATA_W      = 24;
  localparam int             FIFO_DEPTH  = 8;
  localparam int             SYNC_W      = 4;

  typedef enum logic [2:0] {
    XF_IDLE, XF_RCNT, XF_RDAT, XF_WCNT, XF_WDAT, XF_RDATA
  } scd_xfer_t;

  typedef enum logic [1:0] {
    MD_SLEEP, MD_STANDBY, MD_CONV
  } scd_mode_t;

  typedef enum logic [1:0] {
    CK_SYS_OFF, CK_SYS_GAIN, CK_SELF_OFF
  } scd_cal_t;
endpackage

// ---- rtl/scd_sync.sv ----
/*
  Three-stage input synchroniser with agreement filter.
  Assumes inputs are asynchronous levels; output changes once stages two and three agree.
*/
`timescale 1ns/10ps
module scd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // Levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } scd_sync_st_t;

  scd_sync_st_t s_ff, nxt_s;

  // First stage feeds only the second
  always_comb begin
    nxt_s    = s_ff;
    nxt_s.s1 = d_i;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (s_ff.s2[i] == s_ff.s3[i]) begin
        nxt_s.q[i] = s_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q_o = s_ff.q;
endmodule // scd_sync

// ---- rtl/scd_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; depth a power of two.
*/
`timescale 1ns/10ps
module scd_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } scd_fifo_st_t;

  scd_fifo_st_t s_ff, nxt_s;
  logic         push;
  logic         pop;

  assign in_ready_o  = (s_ff.cnt != (AW+1)'(D));
  assign out_valid_o = (s_ff.cnt != '0);
  assign out_data_o  = s_ff.mem[s_ff.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointers and count move together
  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wp] = in_data_i;
      nxt_s.wp           = s_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_s.rp = s_ff.rp + 1'b1;
    end
    nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule // scd_fifo

// ---- rtl/scd_decoder.sv ----
/*
  Serial command decoder: SPI mode-1 slave sampled by the system clock,
  command decode, register file, conversion data buffering and mode control.
  Assumes the converter core gives one-cycle tick per converter clock period
  and hands results through a valid/ready port.
*/
`timescale 1ns/10ps
// What this block does
// - All-zero byte does nothing
// - Wake byte moves power-down to standby
// - Sleep byte aborts, sleeps two ticks later
// - Power-down accepts only read, data-read, wake
// - Reset byte: defaults, internal oscillator, standby
// - Start: continuous repeats, single-shot once
// - Start ignored if pin high or running
// - Stop ends continuous after current result
// - Decode calibrations, update correction registers
// - Self offset shorts inputs to mid-supply
// - Data read returns held buffer copy
// - Register read: address byte, count byte
// - Register bytes MSB first, zeros past end
// - No shift-register load during register access
// - Register access blocks other commands
// - Register write data MSB first, excess ignored
// - Chip select high ends any command
// - Sample on falling, drive on rising edge
// - Timeout resets interface without complete byte
// - Changed setup while converting restarts filter
module scd_decoder
  import scd_pkg::*;
#(
  parameter int TIMEOUT_TCLK = TMO_TCLK
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  // Serial link pins
  input  wire logic                sclk_i,
  input  wire logic                cs_n_i,
  input  wire logic                din_i,
  output logic                     data_out_ready_pin_o,
  output logic                     data_out_oe_n_o,
  output logic                     conversion_ready_flag_n_o,
  // Start pin and converter clock tick
  input  wire logic                start_pin_i,
  input  wire logic                mod_tick_i,
  // Conversion results from the core
  input  wire logic                conv_valid_i,
  output logic                     conv_ready_o,
  input  wire logic [DATA_W-1:0]   conv_data_i,
  // Calibration results from the core
  input  wire logic                cal_done_i,
  input  wire logic [DATA_W-1:0]   cal_value_i,
  // Control to the core
  output logic                     conv_start_o,
  output logic                     conv_abort_o,
  output logic                     filter_rst_o,
  output logic                     converting_o,
  output logic                     sleep_command_o,
  output logic                     int_osc_o,
  output logic                     cal_sys_off_o,
  output logic                     cal_sys_gain_o,
  output logic                     cal_self_off_o,
  output logic                     mid_short_o,
  output logic [NREG*8-1:0]        cfg_o
);
  typedef struct packed {
    logic                  sclk_q;
    logic [2:0]            bitcnt;
    logic [7:0]            rx;
    logic [7:0]            tx;
    logic                  dout;
    scd_xfer_t             xfer;
    logic [4:0]            left;
    logic [4:0]            addr;
    logic [1:0]            dbyte;
    scd_mode_t             mode;
    logic                  start_q;
    logic                  pd_pend;
    logic [1:0]            pd_cnt;
    logic                  stop_pend;
    logic [DATA_W-1:0]     hold;
    logic [DATA_W-1:0]     outd;
    logic                  conversion_ready_flag_n;
    logic [TMO_W-1:0]      tmo;
    scd_cal_t              cal_kind;
    logic                  mid_short;
    logic                  start_p;
    logic                  abort_p;
    logic                  frst_p;
    logic                  so_p;
    logic                  sg_p;
    logic                  sf_p;
    logic [NREG-1:0][7:0]  regs;
  } scd_st_t;

  scd_st_t             s_ff, nxt_s;
  logic [1:0]          rst_ff;
  logic                rst_n;
  logic [SYNC_W-1:0]   pins;
  logic                sclk, cs_n, din, start_pin;
  logic                fifo_valid;
  logic                pop;
  logic [DATA_W-1:0]   fifo_data;

  // Reset released through two flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  // All pins cross into the system clock here
  scd_sync #(.W(SYNC_W)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rst_n),
    .d_i    ({start_pin_i, din_i, cs_n_i, sclk_i}),
    .q_o    (pins)
  );
  assign {start_pin, din, cs_n, sclk} = pins;

  // Results queue; a full queue back-pressures the core
  scd_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (conv_valid_i),
    .in_ready_o  (conv_ready_o),
    .in_data_i   (conv_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (s_ff.xfer != XF_RDATA),
    .out_data_o  (fifo_data)
  );
  // Holding buffer frozen while a data read streams it out
  assign pop = fifo_valid & (s_ff.xfer != XF_RDATA);

  always_comb begin
    logic       fall, rise, done, last7, asleep, act;
    logic [7:0] rxb;
    logic [4:0] base;
    fall   = s_ff.sclk_q & ~sclk & ~cs_n;
    rise   = ~s_ff.sclk_q & sclk & ~cs_n;
    done   = fall & (s_ff.bitcnt == 3'h7);
    last7  = fall & (s_ff.bitcnt == 3'h6);
    rxb    = {s_ff.rx[6:0], din};
    asleep = (s_ff.mode == MD_SLEEP);
    act    = (s_ff.bitcnt != 3'h0) | (s_ff.xfer != XF_IDLE);
    base   = (s_ff.cal_kind == CK_SYS_GAIN) ? FSC_BASE : OFC_BASE;
    nxt_s         = s_ff;
    nxt_s.sclk_q  = sclk;
    nxt_s.start_q = start_pin;
    nxt_s.start_p = 1'b0;
    nxt_s.abort_p = 1'b0;
    nxt_s.frst_p  = 1'b0;
    nxt_s.so_p    = 1'b0;
    nxt_s.sg_p    = 1'b0;
    nxt_s.sf_p    = 1'b0;

    // Bit shifting: sample on fall, drive on rise
    if (fall) begin
      nxt_s.rx     = rxb;
      nxt_s.bitcnt = s_ff.bitcnt + 3'h1;
    end
    if (rise) begin
      nxt_s.dout = s_ff.tx[7];
      nxt_s.tx   = {s_ff.tx[6:0], 1'b0};
      nxt_s.conversion_ready_flag_n = 1'b1;
    end

    // Sleep acts after seven bits, so it is caught early
    if (last7 && s_ff.xfer == XF_IDLE && rxb[6:0] == C7_SLEEP) begin
      nxt_s.pd_pend = 1'b1;
      nxt_s.pd_cnt  = 2'h0;
    end
    if (s_ff.pd_pend && mod_tick_i) begin
      nxt_s.pd_cnt = s_ff.pd_cnt + 2'h1;
      if (s_ff.pd_cnt + 2'h1 == SLEEP_TCLK) begin
        nxt_s.pd_pend   = 1'b0;
        nxt_s.mode      = MD_SLEEP;
        nxt_s.abort_p   = (s_ff.mode == MD_CONV);
        nxt_s.stop_pend = 1'b0;
      end
    end

    // Idle stream shows the direct-read copy, bytes in rotation
    if (done && s_ff.xfer == XF_IDLE) begin
      nxt_s.tx    = (s_ff.dbyte == 2'h1) ? s_ff.outd[15:8] :
                    (s_ff.dbyte == 2'h2) ? s_ff.outd[7:0] : s_ff.outd[23:16];
      nxt_s.dbyte = (s_ff.dbyte >= 2'h2) ? 2'h0 : s_ff.dbyte + 2'h1;
    end

    // Byte decode
    if (done) begin
      nxt_s.tmo = '0;
      case (s_ff.xfer)
        XF_IDLE: begin
          if (rxb[7:5] == C3_REGISTER_READ_CMD) begin
            nxt_s.xfer = XF_RCNT;
            nxt_s.addr = rxb[4:0];
          end else if (rxb[7:1] == C7_RDATA) begin
            nxt_s.xfer  = XF_RDATA;
            nxt_s.tx    = s_ff.hold[23:16];
            nxt_s.dbyte = 2'h1;
          end else if (rxb[7:1] == C7_WAKE) begin
            if (asleep) nxt_s.mode = MD_STANDBY;
          end else if (asleep || rxb == C_NOP) begin
            nxt_s.xfer = XF_IDLE;
          end else if (rxb[7:5] == C3_REGISTER_WRITE_CMD) begin
            nxt_s.xfer = XF_WCNT;
            nxt_s.addr = rxb[4:0];
          end else if (rxb[7:1] == C7_RESET) begin
            nxt_s.regs      = {NREG{REG_DFLT}};
            nxt_s.mode      = MD_STANDBY;
            nxt_s.frst_p    = 1'b1;
            nxt_s.abort_p   = (s_ff.mode == MD_CONV);
            nxt_s.stop_pend = 1'b0;
            nxt_s.pd_pend   = 1'b0;
            nxt_s.mid_short = 1'b0;
          end else if (rxb[7:1] == C7_START) begin
            if (!start_pin && s_ff.mode == MD_STANDBY) begin
              nxt_s.mode    = MD_CONV;
              nxt_s.start_p = 1'b1;
            end
          end else if (rxb[7:1] == C7_STOP) begin
            if (s_ff.mode == MD_CONV && !s_ff.regs[MODE_REG][SINGLE_BIT]) begin
              nxt_s.stop_pend = 1'b1;
            end
          end else if (rxb == C_SYS_OFF) begin
            nxt_s.so_p     = 1'b1;
            nxt_s.cal_kind = CK_SYS_OFF;
          end else if (rxb == C_SYS_GAIN) begin
            nxt_s.sg_p     = 1'b1;
            nxt_s.cal_kind = CK_SYS_GAIN;
          end else if (rxb == C_SELF_OFF) begin
            nxt_s.sf_p      = 1'b1;
            nxt_s.cal_kind  = CK_SELF_OFF;
            nxt_s.mid_short = 1'b1;
          end
        end
        XF_RCNT, XF_RDAT: begin
          if (s_ff.xfer == XF_RCNT) begin
            nxt_s.left = rxb[4:0];
          end else begin
            nxt_s.left = s_ff.left - 5'h1;
          end
          if (s_ff.xfer == XF_RDAT && s_ff.left == 5'h0) begin
            nxt_s.xfer = XF_IDLE;
          end else begin
            nxt_s.xfer = XF_RDAT;
            nxt_s.addr = s_ff.addr + 5'h1;
            nxt_s.tx   = (int'(s_ff.addr) < NREG) ? s_ff.regs[s_ff.addr] : 8'h00;
          end
        end
        XF_WCNT: begin
          nxt_s.left = rxb[4:0];
          nxt_s.xfer = XF_WDAT;
        end
        XF_WDAT: begin
          if (int'(s_ff.addr) < NREG) begin
            nxt_s.regs[s_ff.addr] = rxb;
            if (RESTART_SET[s_ff.addr] && s_ff.mode == MD_CONV &&
                s_ff.regs[s_ff.addr] != rxb) begin
              nxt_s.frst_p  = 1'b1;
              nxt_s.start_p = 1'b1;
            end
          end
          nxt_s.addr = s_ff.addr + 5'h1;
          nxt_s.left = s_ff.left - 5'h1;
          if (s_ff.left == 5'h0) nxt_s.xfer = XF_IDLE;
        end
        XF_RDATA: begin
          nxt_s.tx    = (s_ff.dbyte == 2'h1) ? s_ff.hold[15:8] : s_ff.hold[7:0];
          nxt_s.dbyte = s_ff.dbyte + 2'h1;
          if (s_ff.dbyte == 2'h3) begin
            nxt_s.xfer  = XF_IDLE;
            nxt_s.dbyte = 2'h0;
          end
        end
        default: nxt_s.xfer = XF_IDLE;
      endcase
    end

    // Start pin edge also begins conversions from standby
    if (start_pin && !s_ff.start_q && s_ff.mode == MD_STANDBY) begin
      nxt_s.mode    = MD_CONV;
      nxt_s.start_p = 1'b1;
    end

    // New result: holding copy always, shift copy only outside register access
    if (pop) begin
      nxt_s.hold   = fifo_data;
      nxt_s.conversion_ready_flag_n = 1'b0;
      if (s_ff.xfer == XF_IDLE || s_ff.xfer == XF_RDATA) begin
        nxt_s.outd  = fifo_data;
        nxt_s.dbyte = 2'h0;
        nxt_s.tx    = fifo_data[23:16];
      end
      if (s_ff.mode == MD_CONV &&
          (s_ff.regs[MODE_REG][SINGLE_BIT] || s_ff.stop_pend)) begin
        nxt_s.mode      = MD_STANDBY;
        nxt_s.stop_pend = 1'b0;
      end
    end

    // Calibration result lands in the correction registers
    if (cal_done_i) begin
      if (!nxt_s.sf_p) nxt_s.mid_short = 1'b0;
      for (int i = 0; i < 3; i++) begin
        nxt_s.regs[base + 5'(i)] = cal_value_i[8*i +: 8];
      end
    end

    // Interface timeout counts converter clocks while a byte or a multi-byte command is open
    if (act && !cs_n && mod_tick_i && !done && s_ff.regs[SYS_REG][TMO_BIT]) begin
      nxt_s.tmo = s_ff.tmo + 1'b1;
      if (s_ff.tmo == TMO_W'(TIMEOUT_TCLK - 1)) begin
        nxt_s.tmo    = '0;
        nxt_s.bitcnt = 3'h0;
        nxt_s.xfer   = XF_IDLE;
      end
    end

    // Chip select high drops any command in flight
    if (cs_n) begin
      nxt_s.bitcnt = 3'h0;
      nxt_s.xfer   = XF_IDLE;
      nxt_s.tmo    = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_ff        <= '0;
      s_ff.mode   <= MD_STANDBY;
      s_ff.conversion_ready_flag_n <= 1'b1;
      s_ff.dout   <= 1'b1;
      s_ff.regs   <= {NREG{REG_DFLT}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Idle pin shows ready flag until the first data edge
  assign data_out_ready_pin_o      = (s_ff.bitcnt == 3'h0 && s_ff.xfer == XF_IDLE &&
                                      !s_ff.sclk_q) ? s_ff.conversion_ready_flag_n : s_ff.dout;
  assign data_out_oe_n_o           = cs_n;
  assign conversion_ready_flag_n_o = s_ff.conversion_ready_flag_n;
  assign conv_start_o              = s_ff.start_p;
  assign conv_abort_o              = s_ff.abort_p;
  assign filter_rst_o              = s_ff.frst_p;
  assign converting_o              = (s_ff.mode == MD_CONV);
  assign sleep_command_o               = (s_ff.mode == MD_SLEEP);
  assign int_osc_o                 = ~s_ff.regs[MODE_REG][EXTCLK_BIT];
  assign cal_sys_off_o             = s_ff.so_p;
  assign cal_sys_gain_o            = s_ff.sg_p;
  assign cal_self_off_o            = s_ff.sf_p;
  assign mid_short_o               = s_ff.mid_short;
  assign cfg_o                     = s_ff.regs;
endmodule // scd_decoder

// ---- verification/scd_sva.sv ----
/* Port checker for the serial command decoder.
   Assumes it is bound to scd_decoder and only watches its ports. */
`timescale 1ns/10ps
module scd_sva
  import scd_pkg::*;
#(
  parameter int TIMEOUT_TCLK = TMO_TCLK
) (
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              rstn_i,
  // Pins and tick
  input wire logic              cs_n_i,
  input wire logic              mod_tick_i,
  input wire logic              data_out_oe_n_o,
  // Control outputs
  input wire logic              conv_start_o,
  input wire logic              conv_abort_o,
  input wire logic              converting_o,
  input wire logic              sleep_command_o,
  input wire logic              int_osc_o,
  input wire logic              cal_sys_off_o,
  input wire logic              cal_sys_gain_o,
  input wire logic              cal_self_off_o,
  input wire logic              mid_short_o,
  input wire logic [NREG*8-1:0] cfg_o
);
  logic [3:0] up_ff;

  // Cycles since release; the pin synchroniser needs a few to settle
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i) up_ff <= 4'h0;
    else if (up_ff != 4'hf) up_ff <= up_ff + 4'h1;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_oe_idle; (up_ff == 4'hf && cs_n_i) [*8] |-> data_out_oe_n_o; endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while deselected");
  property p_cs_quiet; cs_n_i [*8] |-> !(cal_sys_off_o || cal_sys_gain_o || cal_self_off_o);
  endproperty
  a_cs_quiet: assert property (p_cs_quiet)
    else $error("command decoded while deselected");
  property p_abort; conv_abort_o |-> ##[0:2] !converting_o; endproperty
  a_abort: assert property (p_abort)
    else $error("conversion kept after abort");
  property p_pd_tick; $rose(sleep_command_o) |-> $past(mod_tick_i); endproperty
  a_pd_tick: assert property (p_pd_tick)
    else $error("power-down not on a converter tick");
  property p_pd_start; sleep_command_o |-> !conv_start_o; endproperty
  a_pd_start: assert property (p_pd_start)
    else $error("start in power-down");
  property p_pd_cal; sleep_command_o |-> !(cal_sys_off_o || cal_sys_gain_o || cal_self_off_o);
  endproperty
  a_pd_cal: assert property (p_pd_cal)
    else $error("calibration in power-down");
  property p_mid; cal_self_off_o |-> ##[0:2] mid_short_o; endproperty
  a_mid: assert property (p_mid)
    else $error("inputs not shorted for self offset");
  property p_cal_one; $onehot0({cal_sys_off_o, cal_sys_gain_o, cal_self_off_o}); endproperty
  a_cal_one: assert property (p_cal_one)
    else $error("two calibrations at once");
  // Mode register clock-select bit sits at 8*4+6
  property p_osc; $changed(cfg_o[38]) |-> ##[0:1] (int_osc_o != cfg_o[38]); endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator select does not follow mode register");
  property p_start_run; conv_start_o |-> ##[0:2] converting_o; endproperty
  a_start_run: assert property (p_start_run)
    else $error("start without conversion");
endmodule // scd_sva

// ---- verification/scd_host.sv ----
/* Host model: mode-1 serial master with framed transfers.
   Assumes clk_i is the bench clock; one bit takes eight of its cycles. */
`timescale 1ns/10ps
module scd_host (
  // Clock and returned data
  input  wire logic clk_i,
  input  wire logic dout_i,
  // Link pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  int         gap = 0;

  // Link idles deselected with the clock low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One framed transfer; the clock stands still outside the frame
  task automatic run();
    logic [7:0] r;
    rx_q = {};
    cs_n_o <= 1'b0;
    tick(4);
    foreach (tx_q[k]) begin
      for (int i = 7; i >= 0; i--) begin
        sclk_o <= 1'b1;
        din_o  <= tx_q[k][i];
        tick(4);
        sclk_o <= 1'b0;
        tick(4);
        r[i] = dout_i; // Late in the low phase, after the device update
      end
      rx_q.push_back(r);
      tick(gap); // Optional stall with the clock low, byte boundary left open
    end
    din_o <= 1'b0;
    tick(4);
    cs_n_o <= 1'b1;
    tick(8);
  endtask
endmodule // scd_host

// ---- verification/testbench.sv ----
/* Self-checking bench for the serial command decoder.
   Assumes scd_host drives the link and scd_sva is bound below. */
`timescale 1ns/10ps
module testbench;
  import scd_pkg::*;
  logic              clk_i, rstn_i, sclk, cs_n, din, dout, oe_n, conversion_ready_flag_n;
  logic              start_pin, tick, cv, cr, cal_done, cst, cab, conv, pd, osc, csf, mid, frst;
  logic [DATA_W-1:0] cdat, cal_val;
  logic [NREG*8-1:0] cfg;
  logic [1:0]        tcnt;
  int                error_cnt, n_tests, n_st, n_sf, n_ab, n_fr, s;

  scd_host host (.clk_i(clk_i), .dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

  // Timeout above one byte time (16 ticks), so only a stall inside a byte or in an open command trips it
  scd_decoder #(.TIMEOUT_TCLK(64)) DUT (
    .clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .data_out_ready_pin_o(dout), .data_out_oe_n_o(oe_n), .conversion_ready_flag_n_o(conversion_ready_flag_n),
    .start_pin_i(start_pin), .mod_tick_i(tick), .conv_valid_i(cv), .conv_ready_o(cr),
    .conv_data_i(cdat), .cal_done_i(cal_done), .cal_value_i(cal_val), .conv_start_o(cst),
    .conv_abort_o(cab), .filter_rst_o(frst), .converting_o(conv), .sleep_command_o(pd),
    .int_osc_o(osc), .cal_sys_off_o(), .cal_sys_gain_o(), .cal_self_off_o(csf),
    .mid_short_o(mid), .cfg_o(cfg));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Converter tick every fourth cycle; pulse counters
  always @(posedge clk_i) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
    if (cst === 1'b1) n_st++;
    if (csf === 1'b1) n_sf++;
    if (cab === 1'b1) n_ab++;
    if (frst === 1'b1) n_fr++;
  end

  task automatic bad(input logic [23:0] g, input logic [23:0] e);
    error_cnt++;
    $display("mismatch at %0t: got %h expected %h", $time, g, e);
  endtask
  task automatic chkf(input logic g, input logic e);
    n_tests++;
    if (g !== e) bad(24'(g), 24'(e));
  endtask
  task automatic chkv(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e) bad(g, e);
  endtask
  task automatic xf(input logic [7:0] b[$]);
    host.tx_q = b;
    host.run();
  endtask
  function automatic logic [23:0] rx3(input int k);
    return {host.rx_q[k], host.rx_q[k+1], host.rx_q[k+2]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic t_reset();
    chkf(pd, 1'b0);
    chkf(conv, 1'b0);
    chkf(osc, 1'b1);
    chkf(conversion_ready_flag_n, 1'b1);
    chkf(|cfg, 1'b0);
  endtask

  task automatic t_regs();
    xf({8'h42, 8'h01, 8'ha5, 8'h3c});
    chkv(24'(cfg[16+:8]), 24'ha5);
    xf({8'h22, 8'h02, 8'h00, 8'h00, 8'h00});
    chkv(rx3(2), 24'ha53c00);
    xf({8'h51, 8'h01, 8'h77, 8'h99});
    xf({8'h30, 8'h02, 8'h00, 8'h00, 8'h00});
    chkv(rx3(2), 24'h007700);
  endtask

  task automatic t_conv();
    s = n_st;
    xf({8'h08});
    chkv(24'(n_st - s), 24'h1);
    chkf(conv, 1'b1);
    xf({8'h09});
    chkv(24'(n_st - s), 24'h1);
    xf({8'h00});
    chkf(conv, 1'b1);
    xf({8'h19}); // Host calibrates only while converting
    chkv(24'(n_sf), 24'h1);
    chkf(mid, 1'b1);
    cal_val <= 24'habcdef;
    cal_done <= 1'b1;
    cyc(1);
    cal_done <= 1'b0;
    cyc(4);
    chkv(cfg[80+:24], 24'habcdef);
    xf({8'h17});
    cal_val <= 24'h654321;
    cal_done <= 1'b1;
    cyc(1);
    cal_done <= 1'b0;
    cyc(4);
    chkv(cfg[104+:24], 24'h654321);
    xf({8'h0a});
    chkf(conv, 1'b1);
    cdat <= 24'h123456;
    cv <= 1'b1;
    cyc(1);
    cv <= 1'b0;
    cyc(8);
    chkf(conv, 1'b0);
    chkf(conversion_ready_flag_n, 1'b0);
    xf({8'h13, 8'h00, 8'h00, 8'h00});
    chkv(rx3(1), 24'h123456);
  endtask

  // Results arrive during a data read; the buffer must fill and refuse
  task automatic t_fill();
    fork
      xf({8'h12, 8'h00, 8'h00, 8'h00});
      begin
        cyc(90);
        for (int i = 0; i < 8; i++) begin
          cdat <= 24'h000100 + 24'(i);
          cv <= 1'b1;
          cyc(1);
          chkf(cr, 1'b1);
        end
        cv <= 1'b0;
        cyc(1);
        chkf(cr, 1'b0);
      end
    join
    chkv(rx3(1), 24'h123456);
    cyc(20);
    chkf(cr, 1'b1);
    xf({8'h12, 8'h00, 8'h00, 8'h00});
    chkv(rx3(1), 24'h000107);
  endtask

  task automatic t_abort();
    s = n_st;
    xf({8'h42});
    xf({8'h08});
    chkv(24'(n_st - s), 24'h1);
    s = n_fr;
    xf({8'h44, 8'h00, 8'h40});
    chkv(24'(n_fr - s), 24'h1);
    chkf(osc, 1'b0);
    xf({8'h06});
    cyc(64); // Recovery delay before the next command
    chkv(24'(n_fr - s), 24'h2);
    chkf(osc, 1'b1);
    chkf(conv, 1'b0);
    chkv(cfg[16+:24], 24'h0);
    xf({8'h08});
  endtask

  task automatic t_sleep();
    xf({8'h42, 8'h00, 8'h5a});
    s = n_ab;
    xf({8'h05});
    cyc(16);
    chkf(pd, 1'b1);
    chkv(24'(n_ab - s), 24'h1);
    s = n_st;
    xf({8'h08});
    chkv(24'(n_st - s), 24'h0);
    xf({8'h22, 8'h00, 8'h00});
    chkv(24'(host.rx_q[2]), 24'h5a);
    xf({8'h03});
    chkf(pd, 1'b0);
  endtask

  // Command left open at a byte boundary past the timeout is dropped; the next byte is a fresh command
  task automatic t_tmo();
    xf({8'h49, 8'h00, 8'h02});
    host.gap = 300;
    xf({8'h22, 8'h08});
    host.gap = 0;
    chkf(conv, 1'b1);
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {rstn_i, start_pin, tick, cv, cal_done, tcnt} = '0;
    {cdat, cal_val} = '0;
    {error_cnt, n_tests, n_st, n_sf, n_ab, n_fr} = '0;
    cyc(16);
    rstn_i <= 1'b1;
    cyc(16);
    t_reset();
    t_regs();
    t_conv();
    t_fill();
    t_abort();
    t_sleep();
    t_tmo();
    conclude();
  end

  // Whole run is some 4800 cycles; cut a hang well beyond that
  initial begin
    #80us;
    error_cnt++;
    conclude();
  end
endmodule // testbench

bind scd_decoder scd_sva #(.TIMEOUT_TCLK(TIMEOUT_TCLK)) u_sva (
  .clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .mod_tick_i(mod_tick_i),
  .data_out_oe_n_o(data_out_oe_n_o), .conv_start_o(conv_start_o),
  .conv_abort_o(conv_abort_o), .converting_o(converting_o), .sleep_command_o(sleep_command_o),
  .int_osc_o(int_osc_o), .cal_sys_off_o(cal_sys_off_o), .cal_sys_gain_o(cal_sys_gain_o),
  .cal_self_off_o(cal_self_off_o), .mid_short_o(mid_short_o), .cfg_o(cfg_o));
